// [rtl/hpec_defs.svh]
// Offsets, field positions and reset values of the hub port electrical configuration bank.
// Included by the package only; the design modules use the macros without including it; definitions only.
`ifndef HPEC_DEFS_SVH
`define HPEC_DEFS_SVH

`define HPEC_ADDR_W           8
`define HPEC_DATA_W           8
`define HPEC_OFF_PWR_DELAY    8'hee
`define HPEC_OFF_UP_BOOST     8'hef
`define HPEC_OFF_DN_BOOST     8'hf0
`define HPEC_OFF_EXCHANGE     8'hf1

`define HPEC_UP_LVL_LO        0
`define HPEC_UP_LVL_HI        1
`define HPEC_P2_LVL_LO        2
`define HPEC_P2_LVL_HI        3
`define HPEC_P3_LVL_LO        4
`define HPEC_P3_LVL_HI        5

`define HPEC_UP_MASK          8'h03
`define HPEC_DN_MASK          8'h3c
`define HPEC_EXCH_MASK        8'h0d

`define HPEC_RST_PWR_DELAY    8'h32
`define HPEC_RST_BOOST        8'h00
`define HPEC_RST_EXCHANGE     8'h00
`define HPEC_ZERO_BYTE        8'h00

`define HPEC_DELAY_UNIT_MS    2
`define HPEC_NUM_PORTS        4

`endif

// [rtl/hpec_pkg.sv]
// Types shared by the hub port electrical configuration bank.
// Constants live in hpec_defs.svh.
package hpec_pkg;
  `include "hpec_defs.svh"

  typedef enum logic [1:0] {
    HPEC_BOOST_NONE,
    HPEC_BOOST_LOW,
    HPEC_BOOST_MED,
    HPEC_BOOST_HIGH
  } hpec_boost_t;

  typedef logic [`HPEC_DATA_W-1:0] hpec_byte_t;
  typedef logic [`HPEC_ADDR_W-1:0] hpec_addr_t;
endpackage

// [rtl/hpec_pin_swap.sv]
// One port's D+/D- to pin routing, both directions.
// Assumes the exchange control is static while traffic flows.
`timescale 1ns/100ps
module hpec_pin_swap (
  // Control
  input  wire logic exchange,
  // Transceiver side
  input  wire logic dp_tx,
  input  wire logic dm_tx,
  output wire logic dp_rx,
  output wire logic dm_rx,
  // Pad side
  output wire logic pos_out,
  output wire logic neg_out,
  input  wire logic pos_in,
  input  wire logic neg_in
);
  assign pos_out = exchange ? dm_tx : dp_tx;
  assign neg_out = exchange ? dp_tx : dm_tx;
  assign dp_rx   = exchange ? neg_in : pos_in;
  assign dm_rx   = exchange ? pos_in : neg_in;
endmodule

// [rtl/hpec_regs.sv]
// Register bank holding power-good delay, drive boost and pin exchange settings.
// Assumes a plain strobe port master; read data valid the cycle after the strobe.
`timescale 1ns/100ps
module hpec_regs
  import hpec_pkg::*;
(
  // Clock and reset
  input  wire logic                    clk_sys,
  input  wire logic                    rstn,
  // Register port
  input  wire hpec_pkg::hpec_addr_t    reg_addr,
  input  wire hpec_pkg::hpec_byte_t    reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output hpec_pkg::hpec_byte_t         reg_rdata,
  // Descriptor side
  output hpec_pkg::hpec_byte_t         power_good_delay,
  // Transceiver drive
  output hpec_pkg::hpec_boost_t        upstream_drive_level,
  output hpec_pkg::hpec_boost_t        port2_drive_level,
  output hpec_pkg::hpec_boost_t        port3_drive_level,
  // Per-port transceiver side
  input  wire logic [3:0]              dp_tx,
  input  wire logic [3:0]              dm_tx,
  output wire logic [3:0]              dp_rx,
  output wire logic [3:0]              dm_rx,
  // Per-port pads
  output wire logic [3:0]              pos_out,
  output wire logic [3:0]              neg_out,
  input  wire logic [3:0]              pos_in,
  input  wire logic [3:0]              neg_in
);
  import hpec_pkg::*;

  hpec_byte_t delay_r;
  hpec_byte_t up_r;
  hpec_byte_t dn_r;
  hpec_byte_t exch_r;
  hpec_byte_t rdata_r;
  hpec_byte_t rdata_nxt;

  wire hit_delay = (reg_addr == `HPEC_OFF_PWR_DELAY);
  wire hit_up    = (reg_addr == `HPEC_OFF_UP_BOOST);
  wire hit_dn    = (reg_addr == `HPEC_OFF_DN_BOOST);
  wire hit_exch  = (reg_addr == `HPEC_OFF_EXCHANGE);

  // Writes store only implemented bits, so reserved bits stay zero
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      delay_r <= `HPEC_RST_PWR_DELAY;
      up_r    <= `HPEC_RST_BOOST;
      dn_r    <= `HPEC_RST_BOOST;
      exch_r  <= `HPEC_RST_EXCHANGE;
    end else if (reg_wr) begin
      if (hit_delay) delay_r <= reg_wdata;
      if (hit_up)    up_r    <= reg_wdata & `HPEC_UP_MASK;
      if (hit_dn)    dn_r    <= reg_wdata & `HPEC_DN_MASK;
      if (hit_exch)  exch_r  <= reg_wdata & `HPEC_EXCH_MASK;
    end
  end

  // Unmapped addresses read as zero
  assign rdata_nxt = hit_delay ? delay_r :
                     hit_up    ? up_r    :
                     hit_dn    ? dn_r    :
                     hit_exch  ? exch_r  : `HPEC_ZERO_BYTE;

  always_ff @(posedge clk_sys) begin
    if (!rstn)       rdata_r <= `HPEC_ZERO_BYTE;
    else if (reg_rd) rdata_r <= rdata_nxt;
    else             rdata_r <= `HPEC_ZERO_BYTE;
  end
  assign reg_rdata = rdata_r;

  // Delay is in 2 ms steps; the host side scales it, not this bank
  assign power_good_delay     = delay_r;
  // Hardware applies any code it is given; keeping 00 is software's job
  assign upstream_drive_level = hpec_boost_t'(up_r[`HPEC_UP_LVL_HI:`HPEC_UP_LVL_LO]);
  assign port2_drive_level    = hpec_boost_t'(dn_r[`HPEC_P2_LVL_HI:`HPEC_P2_LVL_LO]);
  assign port3_drive_level    = hpec_boost_t'(dn_r[`HPEC_P3_LVL_HI:`HPEC_P3_LVL_LO]);

  // Bit 1 is reserved and held zero, so port 1 never swaps
  genvar gi;
  generate
    for (gi = 0; gi < `HPEC_NUM_PORTS; gi++) begin : g_port
      hpec_pin_swap u_swap (
        .exchange (exch_r[gi]),
        .dp_tx    (dp_tx[gi]),
        .dm_tx    (dm_tx[gi]),
        .dp_rx    (dp_rx[gi]),
        .dm_rx    (dm_rx[gi]),
        .pos_out  (pos_out[gi]),
        .neg_out  (neg_out[gi]),
        .pos_in   (pos_in[gi]),
        .neg_in   (neg_in[gi])
      );
    end
  endgenerate

  // Write effects on the configuration outputs
  a_delay_write: assert property (@(posedge clk_sys) disable iff (!rstn)
    reg_wr && hit_delay |=> power_good_delay == $past(reg_wdata))
    else $error("power good delay not updated");

  a_up_reserved: assert property (@(posedge clk_sys) disable iff (!rstn)
    (up_r & ~`HPEC_UP_MASK) == `HPEC_ZERO_BYTE)
    else $error("upstream reserved bits set");

  a_up_level: assert property (@(posedge clk_sys) disable iff (!rstn)
    reg_wr && hit_up |=> upstream_drive_level ==
      hpec_boost_t'($past(reg_wdata[`HPEC_UP_LVL_HI:`HPEC_UP_LVL_LO])))
    else $error("upstream level wrong");

  a_p2_level: assert property (@(posedge clk_sys) disable iff (!rstn)
    reg_wr && hit_dn |=> port2_drive_level ==
      hpec_boost_t'($past(reg_wdata[`HPEC_P2_LVL_HI:`HPEC_P2_LVL_LO])))
    else $error("port 2 level wrong");

  a_p3_level: assert property (@(posedge clk_sys) disable iff (!rstn)
    reg_wr && hit_dn |=> port3_drive_level ==
      hpec_boost_t'($past(reg_wdata[`HPEC_P3_LVL_HI:`HPEC_P3_LVL_LO])))
    else $error("port 3 level wrong");

  a_exch_write: assert property (@(posedge clk_sys) disable iff (!rstn)
    reg_wr && hit_exch |=> exch_r == ($past(reg_wdata) & `HPEC_EXCH_MASK))
    else $error("exchange bits not updated");

  // Settings must not drift between writes
  a_delay_hold: assert property (@(posedge clk_sys) disable iff (!rstn)
    !(reg_wr && hit_delay) |=> $stable(power_good_delay))
    else $error("power good delay changed without write");

  a_up_hold: assert property (@(posedge clk_sys) disable iff (!rstn)
    !(reg_wr && hit_up) |=> $stable(upstream_drive_level))
    else $error("upstream level changed without write");

  a_dn_hold: assert property (@(posedge clk_sys) disable iff (!rstn)
    !(reg_wr && hit_dn) |=> $stable(port2_drive_level) && $stable(port3_drive_level))
    else $error("downstream level changed without write");

  a_exch_hold: assert property (@(posedge clk_sys) disable iff (!rstn)
    !(reg_wr && hit_exch) |=> $stable(exch_r))
    else $error("exchange bits changed without write");

  // Reset values land one edge after reset is sampled
  a_reset_values: assert property (@(posedge clk_sys)
    !rstn |=> power_good_delay == `HPEC_RST_PWR_DELAY && exch_r == `HPEC_RST_EXCHANGE)
    else $error("reset values wrong");

  // Reserved bits and read data
  a_dn_reserved: assert property (@(posedge clk_sys) disable iff (!rstn)
    (dn_r & ~`HPEC_DN_MASK) == `HPEC_ZERO_BYTE)
    else $error("downstream reserved bits set");

  a_exch_reserved: assert property (@(posedge clk_sys) disable iff (!rstn)
    (exch_r & ~`HPEC_EXCH_MASK) == `HPEC_ZERO_BYTE)
    else $error("exchange reserved bits set");

  a_dn_readback: assert property (@(posedge clk_sys) disable iff (!rstn)
    reg_wr && hit_dn ##1 reg_rd && hit_dn |=>
      reg_rdata == ($past(reg_wdata, 2) & `HPEC_DN_MASK))
    else $error("downstream readback wrong");

  a_delay_readback: assert property (@(posedge clk_sys) disable iff (!rstn)
    reg_rd && hit_delay |=> reg_rdata == $past(delay_r))
    else $error("delay readback wrong");

  a_unmapped_read: assert property (@(posedge clk_sys) disable iff (!rstn)
    reg_rd && !(hit_delay || hit_up || hit_dn || hit_exch) |=> reg_rdata == `HPEC_ZERO_BYTE)
    else $error("unmapped read not zero");

  a_idle_rdata: assert property (@(posedge clk_sys) disable iff (!rstn)
    !reg_rd |=> reg_rdata == `HPEC_ZERO_BYTE)
    else $error("read data outside read slot");

  // Pin routing
  a_swap_route: assert property (@(posedge clk_sys) disable iff (!rstn)
    pos_out[0] == (exch_r[0] ? dm_tx[0] : dp_tx[0]) &&
    dp_rx[2] == (exch_r[2] ? neg_in[2] : pos_in[2]))
    else $error("pin routing wrong");

  a_swap_p3: assert property (@(posedge clk_sys) disable iff (!rstn)
    neg_out[3] == (exch_r[3] ? dp_tx[3] : dm_tx[3]) &&
    dm_rx[0] == (exch_r[0] ? pos_in[0] : neg_in[0]))
    else $error("port 3 or port 0 routing wrong");

  a_port1_fixed: assert property (@(posedge clk_sys) disable iff (!rstn)
    pos_out[1] == dp_tx[1] && neg_out[1] == dm_tx[1])
    else $error("port 1 swapped");

  c_boost_high: cover property (@(posedge clk_sys) disable iff (!rstn)
    upstream_drive_level == HPEC_BOOST_HIGH);
  c_swap_p3: cover property (@(posedge clk_sys) disable iff (!rstn) exch_r[3]);
  c_read_after_write: cover property (@(posedge clk_sys) disable iff (!rstn)
    reg_wr && hit_delay ##1 reg_rd && hit_delay);
  c_dn_both_high: cover property (@(posedge clk_sys) disable iff (!rstn)
    port2_drive_level == HPEC_BOOST_HIGH && port3_drive_level == HPEC_BOOST_HIGH);
  c_unmapped_write: cover property (@(posedge clk_sys) disable iff (!rstn)
    reg_wr && !(hit_delay || hit_up || hit_dn || hit_exch));
endmodule

// [tb/hpec_line_partner.sv]
// Far-side pad model: drives the pad levels seen by every port.
// Assumes a free clk_sys; levels are redrawn at random every cycle, so a stale value rarely passes.
`timescale 1ns/100ps
module hpec_line_partner (
  // Clock
  input  wire logic       clk_sys,
  // Pads
  output logic      [3:0] pos_in,
  output logic      [3:0] neg_in
);
  initial {pos_in, neg_in} = 8'h5a;
  always @(posedge clk_sys) {pos_in, neg_in} <= 8'($urandom);
endmodule

// [tb/tb.sv]
// Self-checking bench for the configuration bank, against an integer register model.
// Assumes the strobe register port and the pad partner model.
`timescale 1ns/100ps
module tb;
  import hpec_pkg::*;
  logic        clk_sys, rstn, reg_wr, reg_rd;
  hpec_addr_t  reg_addr;
  hpec_byte_t  reg_wdata, reg_rdata, power_good_delay;
  hpec_boost_t upstream_drive_level, port2_drive_level, port3_drive_level;
  logic [3:0]  dp_tx, dm_tx, dp_rx, dm_rx, pos_out, neg_out, pos_in, neg_in, sw;
  int          fail_count, n_compared, cyc, model [256];

  hpec_regs dut (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .power_good_delay(power_good_delay),
    .upstream_drive_level(upstream_drive_level), .port2_drive_level(port2_drive_level),
    .port3_drive_level(port3_drive_level), .dp_tx(dp_tx), .dm_tx(dm_tx), .dp_rx(dp_rx),
    .dm_rx(dm_rx), .pos_out(pos_out), .neg_out(neg_out), .pos_in(pos_in), .neg_in(neg_in));
  hpec_line_partner partner (.clk_sys(clk_sys), .pos_in(pos_in), .neg_in(neg_in));

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Reserved and unmapped bits are dropped here, so reads expect zero there
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    case (a)
      8'hee: model[a] = d;
      8'hef: model[a] = d & 8'h03;
      8'hf0: model[a] = d & 8'h3c;
      8'hf1: model[a] = d & 8'h0d;
      default: ;
    endcase
  endtask

  task automatic rd(logic [7:0] a);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk("reg_rdata", 8'(model[a]), reg_rdata);
  endtask

  task automatic outs();
    #1 sw = 4'(model['hf1]);
    chk("power_good_delay", 8'(model['hee]), power_good_delay);
    chk("upstream_drive_level", 8'(model['hef]), 8'(upstream_drive_level));
    chk("port2_drive_level", 8'(model['hf0] >> 2 & 3), 8'(port2_drive_level));
    chk("port3_drive_level", 8'(model['hf0] >> 4 & 3), 8'(port3_drive_level));
    chk("pads out", {dp_tx & ~sw | dm_tx & sw, dm_tx & ~sw | dp_tx & sw}, {pos_out, neg_out});
    chk("pads in", {pos_in & ~sw | neg_in & sw, neg_in & ~sw | pos_in & sw}, {dp_rx, dm_rx});
  endtask

  task automatic do_reset();
    @(posedge clk_sys);
    rstn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    foreach (model[k]) model[k] = 0;
    model['hee] = 8'h32;
    outs();
  endtask

  initial begin
    {rstn, reg_wr, reg_rd, reg_addr, reg_wdata, dp_tx, dm_tx} = '0;
    void'($urandom(32'hf105));
    do_reset();
    for (int a = 'hed; a <= 'hf2; a++) rd(8'(a));
    // All 8 exchange patterns, each twice, and every boost code, with junk in reserved bits
    // Nonzero boost codes go against the keep-at-zero advice only to cover them
    for (int i = 0; i < 16; i++) begin
      wr(8'hf1, {4'($urandom), 4'(i)});
      wr(8'hef, {6'($urandom), 2'(i)});
      wr(8'hf0, {2'($urandom), 2'(i), 2'(i >> 2), 2'($urandom)});
      wr(8'hee, 8'($urandom));
      wr(8'($urandom), 8'($urandom));
      dp_tx <= 4'($urandom);
      dm_tx <= 4'($urandom);
      outs();
      for (int a = 'hee; a <= 'hf2; a++) rd(8'(a));
    end
    do_reset();
    rd(8'hee);
    tally_and_finish();
  end
endmodule
